// [rtl/ddr2_cmd_bank.sv]
// DDR2 command decoder, posted column delay, bank state and self refresh control
// Function
// RQ1: ACT decodes on CS,RAS low, CAS,WE high; bank from BA, row A0-A13.
// RQ2: Column command to a bank accepted the cycle after its activate.
// RQ3: Column commands held internally for additive latency 0 to 6 clocks.
// RQ4: Controller precharges a bank before reactivating; honours tRAS and tRP.
// RQ5: Controller spaces activates to one bank by at least tRC.
// RQ6: Controller spaces activates between banks by at least tRRD.
// RQ7: Controller issues at most four activates per rolling tFAW window.
// RQ8: After precharge all, controller waits tRP clocks plus one clock.
// RQ9: Read decodes on CS,CAS low, RAS,WE high; column from A0-A9.
// RQ10: Write decodes on CS,CAS,WE low, RAS high; column from A0-A9.
// RQ11: A10 high with read or write selects auto-precharge; low keeps row open.
// RQ12: Read auto-precharge starts AL+BL/2 after command, once tRAS, tRTP met.
// RQ13: Write auto-precharge starts after burst end plus write recovery.
// RQ14: Precharge with A10 high closes every bank, bank inputs ignored.
// RQ15: Controller turns termination off before self refresh, holds CKE low. The model drives no termination pin, only CKE.
// RQ16: Self refresh uses internal timer, DLL off, inputs but CKE ignored.
// RQ17: Controller may stop clock one cycle after entry; restarts before exit.
// RQ18: Controller sends only NOP or deselect during tXSNR after exit.
// RQ19: Controller keeps CKE high through tXSRD unless re-entering.
// RQ20: Controller issues one refresh after exit before self refresh again.
// RQ21: Auto refresh leaves all banks idle; busy for tRFC.
// RQ22: Controller keeps refresh gaps under nine times tREFI.
// RQ23: Deselect and NOP cause no state change.
// RQ24: Each of eight banks tracked as idle or open.
`timescale 1ns/1ps
`default_nettype none

module ddr2_cmd_bank
    import ddr2_cmd_pkg::*;
#(
    parameter int NB = NUM_BANKS        // Bank count
) (
    input  wire logic            clk_i,         // 50 MHz command clock
    input  wire logic            rst_n_i,       // Synchronous reset, active low
    input  wire logic            cke_i,         // Clock enable pin
    input  wire cmd_pins_t       cmd_i,         // Command, bank and address pins
    input  wire logic [2:0]      al_i,          // Additive latency 0..6
    input  wire logic [3:0]      cl_i,          // CAS latency in clocks
    input  wire logic [3:0]      wr_i,          // Write recovery in clocks
    input  wire logic            bl8_i,         // Burst length 8 when high, else 4
    output act_cmd_t             act_o,         // Activate seen, one-cycle pulse
    output col_cmd_t             col_o,         // Column command after AL, pulse
    output logic [NB-1:0]        bank_open_o,   // Per-bank open row flag
    output logic [NB-1:0]        pre_o,         // Banks closed this cycle, pulse
    output logic                 ref_busy_o,    // Auto refresh in progress
    output logic                 self_ref_o,    // In self refresh
    output logic                 dll_en_o,      // DLL enabled
    output logic                 int_ref_o      // Internal refresh tick, pulse
);

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    pwr_state_t state_ff;
    logic       cke_prev_ff;
    logic       cmd_en;
    logic       is_act;
    logic       is_rd;
    logic       is_wr;
    logic       is_pre;
    logic       is_pre_all;
    logic       is_ref;
    logic       sr_entry;
    logic       sr_exit;

    // Commands only count with CKE high on this and the previous edge
    assign cmd_en     = (state_ff == ST_RUN) && cke_prev_ff && cke_i && !cmd_i.cs_n;   // RQ23
    assign is_act     = cmd_en && !cmd_i.ras_n && cmd_i.cas_n && cmd_i.we_n;           // RQ1
    assign is_rd      = cmd_en && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;           // RQ9
    assign is_wr      = cmd_en && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;          // RQ10
    assign is_pre     = cmd_en && !cmd_i.ras_n && cmd_i.cas_n && !cmd_i.we_n;
    assign is_pre_all = is_pre && cmd_i.addr[AP_BIT];                                  // RQ14
    assign is_ref     = cmd_en && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
    assign sr_entry   = (state_ff == ST_RUN) && cke_prev_ff && !cke_i && !cmd_i.cs_n
                        && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
    assign sr_exit    = (state_ff == ST_SELF_REF) && cke_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cke_prev_ff <= 1'b0;
        end else begin
            cke_prev_ff <= cke_i;
        end
    end

    // ----------------------------------------------------------------
    // Activate report
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            act_o <= '0;
        end else begin
            act_o.valid <= is_act;                                  // RQ1
            act_o.bank  <= cmd_i.ba;
            act_o.row   <= cmd_i.addr;
        end
    end

    // ----------------------------------------------------------------
    // Posted column commands
    // ----------------------------------------------------------------
    col_cmd_t       new_col;
    col_cmd_t       pipe_ff [AL_MAX];
    logic [2:0]     al_sel;

    assign new_col.valid    = is_rd || is_wr;                       // RQ2
    assign new_col.write    = is_wr;                                // RQ10
    assign new_col.auto_pre = cmd_i.addr[AP_BIT];                   // RQ11
    assign new_col.bank     = cmd_i.ba;
    assign new_col.col      = cmd_i.addr[COL_W-1:0];                // RQ9
    // Reserved latency code 7 behaves as the largest supported value
    assign al_sel = (al_i > 3'(AL_MAX)) ? 3'(AL_MAX) : al_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < AL_MAX; i++) begin
                pipe_ff[i] <= '0;
            end
        end else begin
            pipe_ff[0] <= new_col;
            for (int i = 1; i < AL_MAX; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            col_o <= '0;
        end else if (al_sel == 3'h0) begin
            col_o <= new_col;
        end else begin
            col_o <= pipe_ff[al_sel - 3'h1];                        // RQ3
        end
    end

    // ----------------------------------------------------------------
    // Per-bank state and auto-precharge timing
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] rd_ap_cnt;
    logic [CNT_W-1:0] wr_ap_cnt;
    logic [CNT_W-1:0] half_bl;
    logic [NB-1:0]    close_ap;
    logic [NB-1:0]    ras_met;

    assign half_bl   = bl8_i ? CNT_W'(4) : CNT_W'(2);
    // Read: AL + BL/2, pushed out if tRTP from the internal read is longer
    assign rd_ap_cnt = (half_bl > CNT_W'(TRTP_CK)) ? CNT_W'(al_sel) + half_bl
                       : CNT_W'(al_sel) + CNT_W'(TRTP_CK);                       // RQ12
    // Write: WL + BL/2 + WR, with WL = AL + CL - 1
    assign wr_ap_cnt = CNT_W'(al_sel) + CNT_W'(cl_i) - CNT_W'(1) + half_bl
                       + CNT_W'(wr_i);                                           // RQ13

    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic [CNT_W-1:0] ras_cnt_ff;
        logic [CNT_W-1:0] ap_cnt_ff;
        logic             ap_arm_ff;
        logic             hit;

        assign hit        = (cmd_i.ba == BANK_W'(b));
        assign ras_met[b] = (ras_cnt_ff >= CNT_W'(TRAS_CK));
        // Hold at the last count until tRAS is satisfied
        assign close_ap[b] = ap_arm_ff && (ap_cnt_ff == CNT_W'(1)) && ras_met[b];   // RQ12

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                ras_cnt_ff <= '0;
            end else if (is_act && hit) begin
                // Activate edge itself is the first active cycle
                ras_cnt_ff <= CNT_W'(1);
            end else if (!ras_met[b]) begin
                ras_cnt_ff <= ras_cnt_ff + CNT_W'(1);
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                ap_arm_ff <= 1'b0;
                ap_cnt_ff <= '0;
            end else if ((is_rd || is_wr) && hit && cmd_i.addr[AP_BIT]
                         && bank_open_o[b]) begin
                ap_arm_ff <= 1'b1;                                                  // RQ11
                ap_cnt_ff <= is_wr ? wr_ap_cnt : rd_ap_cnt;                         // RQ13
            end else if (close_ap[b] || is_pre_all || is_ref
                         || (is_pre && hit)) begin
                ap_arm_ff <= 1'b0;
            end else if (ap_arm_ff && ap_cnt_ff > CNT_W'(1)) begin
                ap_cnt_ff <= ap_cnt_ff - CNT_W'(1);
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                bank_open_o[b] <= BANK_OPEN_RST[b];
                pre_o[b]       <= 1'b0;
            end else begin
                pre_o[b] <= bank_open_o[b] && (close_ap[b] || is_pre_all || is_ref
                                               || (is_pre && hit));
                if (is_act && hit) begin
                    bank_open_o[b] <= 1'b1;                                         // RQ24
                end else if (close_ap[b] || is_pre_all || is_ref
                             || (is_pre && hit)) begin
                    bank_open_o[b] <= 1'b0;                                         // RQ14
                end
            end
        end

        chk_rd_ap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ12
            (is_rd && hit && cmd_i.addr[AP_BIT] && bank_open_o[b] && al_i == 3'h0 && !bl8_i
             && TRTP_CK <= 2) |-> ##2 close_ap[b] ##1 !bank_open_o[b])
            else $error("read auto-precharge at wrong edge");

        chk_wr_ap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ13
            (is_wr && hit && cmd_i.addr[AP_BIT] && bank_open_o[b] && al_i == 3'h0 && !bl8_i
             && cl_i == 4'h3 && wr_i == 4'h2)
            ##1 (!is_pre && !is_ref && !is_act) [*5]
            |=> bank_open_o[b] ##1 !bank_open_o[b])
            else $error("write auto-precharge timing wrong");
    end

    // ----------------------------------------------------------------
    // Auto refresh busy window
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] rfc_cnt_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rfc_cnt_ff <= '0;
            ref_busy_o <= 1'b0;
        end else if (is_ref) begin
            rfc_cnt_ff <= CNT_W'(TRFC_CK);                          // RQ21
            ref_busy_o <= 1'b1;
        end else if (rfc_cnt_ff > CNT_W'(1)) begin
            rfc_cnt_ff <= rfc_cnt_ff - CNT_W'(1);
        end else begin
            rfc_cnt_ff <= '0;
            ref_busy_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Self refresh
    // ----------------------------------------------------------------
    logic [12:0] refi_cnt_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff   <= ST_RUN;
            self_ref_o <= 1'b0;
            dll_en_o   <= 1'b1;
        end else begin
            unique case (state_ff)
                ST_RUN: begin
                    if (sr_entry) begin
                        state_ff   <= ST_SELF_REF;
                        self_ref_o <= 1'b1;
                        dll_en_o   <= 1'b0;                         // RQ16
                    end
                end
                ST_SELF_REF: begin
                    if (sr_exit) begin
                        state_ff   <= ST_RUN;
                        self_ref_o <= 1'b0;
                        dll_en_o   <= 1'b1;                         // RQ16
                    end
                end
            endcase
        end
    end

    // Internal timer runs only while the device refreshes itself
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            refi_cnt_ff <= '0;
            int_ref_o   <= 1'b0;
        end else if (state_ff == ST_SELF_REF) begin
            int_ref_o <= (refi_cnt_ff == 13'(TREFI_CK - 1));        // RQ16
            if (refi_cnt_ff == 13'(TREFI_CK - 1)) begin
                refi_cnt_ff <= '0;
            end else begin
                refi_cnt_ff <= refi_cnt_ff + 13'h1;
            end
        end else begin
            refi_cnt_ff <= '0;
            int_ref_o   <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_act_opens: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
        is_act |=> act_o.valid && bank_open_o[act_o.bank])
        else $error("activate did not open its bank");

    chk_col_next: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
        (is_act && al_i == 3'h0) ##1 (is_rd && al_i == 3'h0) |=> col_o.valid)
        else $error("column after activate not accepted");

    chk_al_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
        (is_rd && al_i == 3'h2) ##1 (al_i == 3'h2) [*2] |=> col_o.valid && !col_o.write)
        else $error("read not held for additive latency");

    chk_pre_all: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ14
        is_pre_all |=> bank_open_o == '0)
        else $error("precharge all left a bank open");

    chk_ref_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ21
        is_ref |=> bank_open_o == '0 && ref_busy_o)
        else $error("refresh left a bank open");

    chk_sr_dll: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ16
        sr_entry |=> !dll_en_o && self_ref_o && !act_o.valid)
        else $error("self refresh entry wrong");

    chk_desel_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ23
        (cmd_i.cs_n || (cmd_i.ras_n && cmd_i.cas_n && cmd_i.we_n))
        |=> !act_o.valid && !$rose(ref_busy_o))
        else $error("deselect or nop changed state");

endmodule

`default_nettype wire

// [rtl/ddr2_cmd_pkg.sv]
// Shared constants and carrier types for the DDR2 command decoder and bank state logic
package ddr2_cmd_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_BANKS  = 8;
    localparam int BANK_W     = 3;
    localparam int ADDR_W     = 14;
    localparam int COL_W      = 10;
    localparam int AP_BIT     = 10;
    localparam int AL_MAX     = 6;
    localparam int CNT_W      = 8;

    // ----------------------------------------------------------------
    // Timing (ns) and derived clock counts at 50 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 20000;
    localparam int TRAS_NS       = 45;
    localparam int TRTP_NS       = 8;
    localparam int TRFC_NS       = 128;
    localparam int TREFI_NS      = 7800;

    // Least times round up, never below one cycle
    localparam int TRAS_CK  = (TRAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRTP_CK  = ((TRTP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1
                              : (TRTP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRFC_CK  = (TRFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Refresh interval is a longest time: round down
    localparam int TREFI_CK = (TREFI_NS * 1000) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [NUM_BANKS-1:0] BANK_OPEN_RST = 8'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              auto_pre;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  col;
    } col_cmd_t;

    typedef struct packed {
        logic              valid;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
    } act_cmd_t;

    typedef enum logic {
        ST_RUN,
        ST_SELF_REF
    } pwr_state_t;

endpackage

// [sim/ddr2_command_decoder_bank_fsm_tb_top.sv]
// Self-checking bench for the DDR2 command decoder and bank state logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

module ddr2_command_decoder_bank_fsm_tb_top;
    import ddr2_cmd_pkg::*;
    localparam int TRP_CK   = 3;   // Precharge wait the model keeps
    localparam int TXSNR_CK = 10;  // Exit wait the model keeps
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cke;
    cmd_pins_t   cmd;
    logic [2:0]  al = 3'h0;
    logic [3:0]  cl = 4'h3;
    logic [3:0]  wr = 4'h2;
    logic        bl8 = 1'b0;
    act_cmd_t    act;
    col_cmd_t    col;
    logic [7:0]  open_q;
    logic [7:0]  pre_q;
    logic        busy;
    logic        sref;
    logic        dll;
    logic        iref;
    logic [31:0] seed = 32'h0000_0059;
    logic [31:0] r;
    int          k;
    int          failures = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #10 clk = ~clk;

    ddr2_cmd_bank ddr2_cmd_bank_inst (
        .clk_i(clk), .rst_n_i(rst_n), .cke_i(cke), .cmd_i(cmd), .al_i(al), .cl_i(cl),
        .wr_i(wr), .bl8_i(bl8), .act_o(act), .col_o(col), .bank_open_o(open_q),
        .pre_o(pre_q), .ref_busy_o(busy), .self_ref_o(sref), .dll_en_o(dll),
        .int_ref_o(iref));

    ddr2_ctrl_model ddr2_ctrl_model_inst (.clk_i(clk), .cmd_o(cmd), .cke_o(cke));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic cmd_pins_t mk(input logic [3:0] op, input logic [2:0] ba,
                                     input logic [13:0] a);
        return {op, ba, a};
    endfunction

    // Cycles from the column command edge to the bank closing
    function automatic int ap_close(input int a, input logic w);
        int h;
        int t;
        h = bl8 ? 4 : 2;
        if (w) return a + cl - 1 + h + wr;
        t = a + ((h > TRTP_CK) ? h : TRTP_CK);
        return (t > TRAS_CK - 1) ? t : TRAS_CK - 1;
    endfunction

    task automatic snd(input cmd_pins_t c);
        ddr2_ctrl_model_inst.send(c);
    endtask

    task automatic idl(input int n);
        ddr2_ctrl_model_inst.idle(n);
    endtask

    task automatic stop_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Activate, column command right behind it, then close the row
    task automatic rw_case(input logic [2:0] a, input logic w, input logic ap,
                           input logic fix);
        logic [31:0] q;
        int          n;
        int          e;
        q = rnd();
        al = a;
        bl8 = q[27] & ~fix;
        // Latency code 7 runs as the largest supported value
        e = (a > AL_MAX) ? AL_MAX : a;
        idl(2);
        snd(mk(4'h3, q[2:0], q[16:3]));
        `CHK("act", {1'b1, q[2:0], q[16:3]}, act)
        `CHK("open", 1'b1, open_q[q[2:0]])
        snd(mk(w ? 4'h4 : 4'h5, q[2:0], {q[30:28], ap, q[26:17]}));
        n = 0;
        while (col.valid !== 1'b1 && n < 10) begin
            idl(1);
            n++;
        end
        `CHK("col_delay", e, n)
        `CHK("col", {1'b1, w, ap, q[2:0], q[26:17]}, col)
        if (ap) begin
            while (open_q[q[2:0]] === 1'b1 && n < 60) begin
                idl(1);
                n++;
            end
            `CHK("ap_close", ap_close(e, w), n)
            `CHK("ap_pre", 8'h01 << q[2:0], pre_q)
        end else begin
            idl(12);
            `CHK("kept", 1'b1, open_q[q[2:0]])
            snd(mk(4'h2, q[2:0], {q[13:11], 1'b0, q[9:0]}));
            `CHK("pre", 8'h01 << q[2:0], pre_q)
            `CHK("shut", 8'h00, open_q)
        end
        idl(TRP_CK);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        r = rnd();
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        idl(3);
        `CHK("rst_open", 8'h00, open_q)
        `CHK("rst_dll", 1'b1, dll)
        // Shortest latencies and burst of four before the random ones
        rw_case(3'h0, 1'b1, 1'b1, 1'b1);
        rw_case(3'h0, 1'b0, 1'b1, 1'b1);
        cl = 4'h3 + {2'h0, r[1:0]};
        wr = 4'h2 + {2'h0, r[3:2]};
        for (int a = 0; a < 8; a++) begin
            rw_case(a[2:0], 1'b0, a[0], 1'b0);
            rw_case(a[2:0], 1'b1, ~a[0], 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            snd(mk(4'h3, i[2:0], r[13:0]));
            idl(4);
        end
        `CHK("all_open", 8'hFF, open_q)
        snd(mk(4'h7, r[2:0], r[13:0]));
        `CHK("nop_act", 1'b0, act.valid)
        snd(mk(4'hA, r[2:0], 14'h0400));
        `CHK("desel_pre", 8'h00, pre_q)
        `CHK("desel_open", 8'hFF, open_q)
        snd(mk(4'h2, r[2:0], {r[13:11], 1'b1, r[9:0]}));
        `CHK("pre_all", 8'hFF, pre_q)
        `CHK("pre_all_idle", 8'h00, open_q)
        idl(TRP_CK + 1);
        snd(mk(4'h3, 3'h2, r[13:0]));
        idl(4);
        snd(mk(4'h1, r[2:0], r[13:0]));
        `CHK("ref_idle", 8'h00, open_q)
        `CHK("ref_pre", 8'h04, pre_q)
        k = 0;
        while (busy === 1'b1 && k < 50) begin
            idl(1);
            k++;
        end
        `CHK("ref_busy", TRFC_CK, k)
        idl(2);
        ddr2_ctrl_model_inst.self_ref(mk(4'h1, 3'h0, 14'h0000));
        `CHK("sr_in", 1'b1, sref)
        `CHK("dll_off", 1'b0, dll)
        snd(mk(4'h3, 3'h5, r[13:0]));
        `CHK("sr_ignore", 8'h00, open_q)
        k = 0;
        while (iref !== 1'b1 && k < TREFI_CK + 5) begin
            idl(1);
            k++;
        end
        k = 0;
        do begin
            idl(1);
            k++;
        end while (iref !== 1'b1 && k < TREFI_CK + 5);
        `CHK("int_tick", TREFI_CK, k)
        ddr2_ctrl_model_inst.wake();
        `CHK("sr_out", 1'b0, sref)
        `CHK("dll_on", 1'b1, dll)
        idl(TXSNR_CK);
        snd(mk(4'h1, 3'h0, 14'h0000));
        `CHK("ref_after_sr", 1'b1, busy)
        idl(TRFC_CK + 2);
        stop_test();
    end
endmodule

`default_nettype wire

// [sim/ddr2_ctrl_model.sv]
// Behavioural DDR2 controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none

module ddr2_ctrl_model
    import ddr2_cmd_pkg::*;
(
    input  wire logic      clk_i,  // Command clock
    output var  cmd_pins_t cmd_o,  // Command, bank and address pins
    output var  logic      cke_o   // Clock enable
);
    initial begin
        cmd_o = '1;
        cke_o = 1'b1;
    end

    // Caller sits at a falling edge; the command is taken at the next rise
    task automatic send(input cmd_pins_t c);
        cmd_o = c;
        @(negedge clk_i);
    endtask

    // Deselect gaps keep the spacing rules; released pins flip every cycle
    task automatic idle(input int n);
        cmd_pins_t t;
        repeat (n) begin
            t = ~cmd_o;
            t.cs_n = 1'b1;
            cmd_o = t;
            @(negedge clk_i);
        end
    endtask

    // Termination is never driven here; clock kept running through
    task automatic self_ref(input cmd_pins_t c);
        cmd_o = c;
        cke_o = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic wake();
        cmd_o.cs_n = 1'b1;
        cke_o = 1'b1;
        @(negedge clk_i);
    endtask
endmodule

`default_nettype wire
